// file: pmtr_pkg.sv
// ****************************************************************
// Program memory table reader constants and types.
// ****************************************************************
package pmtr_pkg;

  localparam int PMTR_ADDR_W = 14;
  localparam int PMTR_WORD_W = 16;
  localparam int PMTR_DEPTH = 16384;
  localparam logic [13:0] PMTR_RESET_PC = 14'h0000;
  localparam logic [7:0] PMTR_LAST_PAGE = 8'h3F;
  localparam logic [7:0] PMTR_PTR_RST = 8'h00;
  localparam logic [7:0] PMTR_LATCH_RST = 8'h00;
  localparam logic [1:0] PMTR_PHASE_RST = 2'h0;
  localparam int PMTR_HI_PTR_BITS = 6;

  // Request from the core for one table read instruction.
  typedef struct packed {
    logic valid;
    logic last_page;
    logic extended;
    logic [7:0] dest_sector;
    logic [7:0] dest_addr;
  } pmtr_req_type;

  // Write of the low table byte into data memory.
  typedef struct packed {
    logic valid;
    logic [7:0] sector;
    logic [7:0] addr;
    logic [7:0] data;
  } pmtr_dwr_type;

  typedef enum logic [1:0] {
    PMTR_IDLE = 2'b00,
    PMTR_RD1 = 2'b01,
    PMTR_RD2 = 2'b10
  } pmtr_state_type;

endpackage : pmtr_pkg

// file: pmtr_prog_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Serial programmer model sending one bit pattern.
// ****************************************************************
module pmtr_prog_model
#(
  parameter logic [3:0] PAT = 4'hB
)
(
  clk,
  go,
  sclk,
  sdat
);
  input wire logic clk;
  input wire logic go;
  output logic sclk;
  output logic sdat;
  // Clock stands low outside the frame; data is set well before each rise.
  initial
  begin
    sclk = 1'b0;
    sdat = 1'b0;
    @(posedge go);
    for (int i = 3; i >= 0; i--)
    begin
      sdat = PAT[i];
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
    sdat = ~sdat; // Released line shows the inverse.
  end
endmodule : pmtr_prog_model

// file: pmtr_props.sv
`timescale 1ns/100ps
// ****************************************************************
// Port checker for the table reader.
// ****************************************************************
module pmtr_checker
(
  clk,
  rst_n,
  phase,
  instr_cycle_en,
  req,
  busy,
  latch_we,
  wr_data,
  table_high_latch,
  dmem_wr,
  debug_variant,
  shared_func_en
);
  import pmtr_pkg::*;
  input wire logic clk;
  input wire logic rst_n;
  input wire logic [1:0] phase;
  input wire logic instr_cycle_en;
  input wire pmtr_pkg::pmtr_req_type req;
  input wire logic busy;
  input wire logic latch_we;
  input wire logic [7:0] wr_data;
  input wire logic [7:0] table_high_latch;
  input wire pmtr_pkg::pmtr_dwr_type dmem_wr;
  input wire logic debug_variant;
  input wire logic shared_func_en;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A read is taken only by an idle reader at the cycle strobe.
  sequence take_s;
    instr_cycle_en && !busy && req.valid;
  endsequence
  sequence done_s;
    dmem_wr.valid ##1 !dmem_wr.valid;
  endsequence
  a_cycle_strobe: assert property (instr_cycle_en |=> !instr_cycle_en [*3] ##1 instr_cycle_en)
    else $error("cycle strobe not every fourth clock");
  a_strobe_phase: assert property (instr_cycle_en |-> phase == 2'h3)
    else $error("cycle strobe outside last phase");
  a_busy_start: assert property (take_s |=> busy)
    else $error("read not taken");
  a_two_cycles: assert property ($rose(busy) |-> busy [*8] ##1 !busy)
    else $error("read not two instruction cycles");
  a_write_after: assert property ($fell(busy) |-> done_s)
    else $error("low byte write missing");
  a_dest_route: assert property (take_s |-> ##9 dmem_wr.valid
    && dmem_wr.addr == $past(req.dest_addr, 9)
    && dmem_wr.sector == ($past(req.extended, 9) ? $past(req.dest_sector, 9) : 8'h00))
    else $error("destination register wrong");
  a_latch_write: assert property (latch_we && !busy |=> table_high_latch == $past(wr_data))
    else $error("latch write lost");
  a_latch_hold: assert property (!latch_we && !busy |=> $stable(table_high_latch))
    else $error("latch changed without cause");
  a_shared_off: assert property (shared_func_en == !debug_variant)
    else $error("shared pin function not gated");
endmodule : pmtr_checker

bind pmtr_reader pmtr_checker chk_u (.clk, .rst_n, .phase, .instr_cycle_en, .req, .busy,
  .latch_we, .wr_data, .table_high_latch, .dmem_wr, .debug_variant, .shared_func_en);

// file: pmtr_reader.sv
`timescale 1ns/100ps
module pmtr_reader
(
  clk,
  rst_n,
  fetch_pc,
  fetch_data,
  phase,
  instr_cycle_en,
  req,
  busy,
  ptr_lo_we,
  ptr_hi_we,
  latch_we,
  wr_data,
  ptr_lo,
  ptr_hi,
  table_high_latch,
  dmem_wr,
  load_en,
  load_addr,
  load_data,
  debug_variant,
  prog_serial_data_in,
  prog_serial_data_out,
  prog_serial_data_oe,
  prog_serial_clock_line,
  prog_rx_bit,
  prog_rx_valid,
  prog_tx_bit,
  prog_tx_en,
  shared_func_en
);
  input wire logic clk;
  input wire logic rst_n;
  input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] fetch_pc;
  output logic [pmtr_pkg::PMTR_WORD_W-1:0] fetch_data;
  output logic [1:0] phase;
  output logic instr_cycle_en;
  input wire pmtr_pkg::pmtr_req_type req;
  output logic busy;
  input wire logic ptr_lo_we;
  input wire logic ptr_hi_we;
  input wire logic latch_we;
  input wire logic [7:0] wr_data;
  output logic [7:0] ptr_lo;
  output logic [7:0] ptr_hi;
  output logic [7:0] table_high_latch;
  output pmtr_pkg::pmtr_dwr_type dmem_wr;
  input wire logic load_en;
  input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] load_addr;
  input wire logic [pmtr_pkg::PMTR_WORD_W-1:0] load_data;
  input wire logic debug_variant;
  input wire logic prog_serial_data_in;
  output logic prog_serial_data_out;
  output logic prog_serial_data_oe;
  input wire logic prog_serial_clock_line;
  output logic prog_rx_bit;
  output logic prog_rx_valid;
  input wire logic prog_tx_bit;
  input wire logic prog_tx_en;
  output logic shared_func_en;

  import pmtr_pkg::*;

  // ****************************************************************
  // Program store.
  // ****************************************************************

  logic [PMTR_WORD_W-1:0] mem_r [0:PMTR_DEPTH-1];
  logic [PMTR_ADDR_W-1:0] tbl_addr_r;
  logic [PMTR_WORD_W-1:0] tbl_word_r;

  // Forms the 14-bit table address; last page forms pin the page.
  function automatic logic [PMTR_ADDR_W-1:0] pmtr_tbl_addr(
    input logic last_pg,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [7:0] page;
    page = last_pg ? PMTR_LAST_PAGE : hi;
    return {page[PMTR_HI_PTR_BITS-1:0], lo};
  endfunction : pmtr_tbl_addr

  // Store has no reset so it maps onto a memory; loader writes it.
  always_ff @(posedge clk)
  begin
    if (load_en)
    begin
      mem_r[load_addr] <= load_data;
    end
    tbl_word_r <= mem_r[tbl_addr_r];
  end

  // Instruction word read port for the core.
  always_ff @(posedge clk)
  begin
    fetch_data <= mem_r[fetch_pc];
  end

  // ****************************************************************
  // Instruction cycle phases.
  // ****************************************************************

  logic [1:0] phase_r;

  // Four phases per instruction cycle; the cycle enable marks phase three, the last.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_r <= PMTR_PHASE_RST;
    end
    else
    begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign phase = phase_r;
  assign instr_cycle_en = (phase_r == 2'h3);

  // ****************************************************************
  // Pointers and the table high latch.
  // ****************************************************************

  pmtr_state_type state_r;
  pmtr_state_type state_nxt;
  pmtr_req_type req_r;

  // Pointer registers written by software.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_lo <= PMTR_PTR_RST;
      ptr_hi <= PMTR_PTR_RST;
    end
    else
    begin
      if (ptr_lo_we)
      begin
        ptr_lo <= wr_data;
      end
      if (ptr_hi_we)
      begin
        ptr_hi <= wr_data;
      end
    end
  end

  // The hardware load wins over a software write in the same cycle,
  // so a read result is never lost to a stale restore.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      table_high_latch <= PMTR_LATCH_RST;
    end
    else if (state_r == PMTR_RD2 && instr_cycle_en)
    begin
      table_high_latch <= tbl_word_r[15:8];
    end
    else if (latch_we)
    begin
      table_high_latch <= wr_data;
    end
  end

  // ****************************************************************
  // Table read sequencer.
  // ****************************************************************

  // A request is taken at an instruction boundary and spans two cycles.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      PMTR_IDLE:
      begin
        if (instr_cycle_en && req.valid)
        begin
          state_nxt = PMTR_RD1;
        end
      end
      PMTR_RD1:
      begin
        if (instr_cycle_en)
        begin
          state_nxt = PMTR_RD2;
        end
      end
      PMTR_RD2:
      begin
        if (instr_cycle_en)
        begin
          state_nxt = PMTR_IDLE;
        end
      end
      default:
      begin
        state_nxt = PMTR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= PMTR_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Request captured at acceptance; pointers sampled at that moment.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_r <= '0;
      tbl_addr_r <= PMTR_RESET_PC;
    end
    else if (state_r == PMTR_IDLE && instr_cycle_en && req.valid)
    begin
      req_r <= req;
      tbl_addr_r <= pmtr_tbl_addr(req.last_page, ptr_lo, ptr_hi);
    end
  end

  // Low byte is written to data memory at the end of the second cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dmem_wr <= '0;
    end
    else
    begin
      dmem_wr.valid <= (state_r == PMTR_RD2) && instr_cycle_en;
      // Short forms can only reach sector zero.
      dmem_wr.sector <= req_r.extended ? req_r.dest_sector : 8'h00;
      dmem_wr.addr <= req_r.dest_addr;
      dmem_wr.data <= tbl_word_r[7:0];
    end
  end

  assign busy = (state_r != PMTR_IDLE);

  // ****************************************************************
  // Serial programming and debug pins.
  // ****************************************************************

  logic [1:0] sda_sync_r;
  logic [1:0] sck_sync_r;
  logic sck_prev_r;

  // Both pins pass two flip-flops; edges are seen only on stage two.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_sync_r <= 2'b00;
      sck_sync_r <= 2'b00;
      sck_prev_r <= 1'b0;
    end
    else
    begin
      sda_sync_r <= {sda_sync_r[0], prog_serial_data_in};
      sck_sync_r <= {sck_sync_r[0], prog_serial_clock_line};
      sck_prev_r <= sck_sync_r[1];
    end
  end

  // One bit is sampled on each rising clock from the programmer.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_rx_bit <= 1'b0;
      prog_rx_valid <= 1'b0;
      prog_serial_data_out <= 1'b0;
    end
    else
    begin
      prog_rx_valid <= sck_sync_r[1] && !sck_prev_r;
      if (sck_sync_r[1] && !sck_prev_r)
      begin
        prog_rx_bit <= sda_sync_r[1];
      end
      prog_serial_data_out <= prog_tx_bit;
    end
  end

  // The data line is driven only when upload is asked for.
  assign prog_serial_data_oe = prog_tx_en;
  // On the debug variant the pins serve only debug and programming.
  assign shared_func_en = !debug_variant;

endmodule : pmtr_reader

// file: test_pmtr_reader.sv
`timescale 1ns/100ps
// ****************************************************************
// Table reader testbench.
// ****************************************************************
module test_pmtr_reader;
  import pmtr_pkg::*;
  logic clk, rst_n, ptr_lo_we, ptr_hi_we, latch_we, load_en, debug_variant;
  logic prog_serial_clock_line, prog_tx_bit, prog_tx_en, prog_go, prog_sdat;
  logic [13:0] fetch_pc, load_addr;
  logic [15:0] load_data, fetch_data;
  logic [7:0] wr_data, ptr_lo, ptr_hi, table_high_latch, rx_sr;
  logic [1:0] phase;
  logic instr_cycle_en, busy, prog_serial_data_out, prog_serial_data_oe;
  logic prog_rx_bit, prog_rx_valid, shared_func_en, prog_serial_data_in;
  pmtr_req_type req;
  pmtr_dwr_type dmem_wr;
  int n_fail, checks;
  // The shared data line carries whoever enables it.
  assign prog_serial_data_in = prog_serial_data_oe ? prog_serial_data_out : prog_sdat;
  pmtr_reader dut_u (.clk, .rst_n, .fetch_pc, .fetch_data, .phase, .instr_cycle_en, .req,
    .busy, .ptr_lo_we, .ptr_hi_we, .latch_we, .wr_data, .ptr_lo, .ptr_hi, .table_high_latch,
    .dmem_wr, .load_en, .load_addr, .load_data, .debug_variant, .prog_serial_data_in,
    .prog_serial_data_out, .prog_serial_data_oe, .prog_serial_clock_line, .prog_rx_bit,
    .prog_rx_valid, .prog_tx_bit, .prog_tx_en, .shared_func_en);
  pmtr_prog_model prog_u (.clk(clk), .go(prog_go), .sclk(prog_serial_clock_line),
    .sdat(prog_sdat));
  // Received bits are collected in arrival order.
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      rx_sr <= 8'h00;
    else if (prog_rx_valid === 1'b1)
      rx_sr <= {rx_sr[6:0], prog_rx_bit};
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task summarize;
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Strobe one byte into a pointer (0, 1) or the latch (2).
  task wr8(input int sel, input logic [7:0] d);
    @(negedge clk);
    wr_data = d;
    ptr_lo_we = (sel == 0);
    ptr_hi_we = (sel == 1);
    latch_we = (sel == 2);
    @(negedge clk);
    {ptr_lo_we, ptr_hi_we, latch_we} = 3'b000;
  endtask : wr8
  task load(input logic [13:0] a, input logic [15:0] d);
    @(negedge clk);
    {load_en, load_addr, load_data} = {1'b1, a, d};
    @(negedge clk);
    load_en = 1'b0;
  endtask : load
  task t_read(input logic [7:0] lo, hi, input logic lp, ex, input logic [7:0] sec,
    input logic [13:0] a, input logic [15:0] w);
    int n;
    load(a, w);
    wr8(0, lo);
    wr8(1, hi);
    chk({ptr_lo, ptr_hi}, {lo, hi});
    req = '{1'b1, lp, ex, sec, 8'h5A};
    for (n = 0; n < 20 && busy !== 1'b1; n++) @(negedge clk);
    req.valid = 1'b0;
    chk({15'h0000, busy}, 16'h0001);
    // A limit that runs out also fails this count of eight clocks.
    for (n = 0; n < 20 && dmem_wr.valid !== 1'b1; n++) @(negedge clk);
    chk(n[15:0], 16'h0008);
    chk({8'h00, dmem_wr.addr}, 16'h005A);
    chk({8'h00, dmem_wr.data}, {8'h00, w[7:0]});
    chk({8'h00, dmem_wr.sector}, ex ? {8'h00, sec} : 16'h0000);
    chk({8'h00, table_high_latch}, {8'h00, w[15:8]});
  endtask : t_read
  initial
  begin
    #(25 * 3000);
    n_fail++;
    summarize();
  end
  initial
  begin
    {rst_n, ptr_lo_we, ptr_hi_we, latch_we, load_en, debug_variant} = 6'h00;
    {prog_tx_bit, prog_tx_en, prog_go, fetch_pc, load_addr} = 31'h0000_0000;
    {load_data, wr_data} = 24'h00_0000;
    req = '0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk({ptr_hi, table_high_latch}, 16'h0000);
    chk({ptr_lo, ptr_hi}, 16'h0000);
    chk({15'h0000, shared_func_en}, 16'h0001);
    load(14'h0000, 16'h1234);
    @(negedge clk);
    chk(fetch_data, 16'h1234);
    t_read(8'h06, 8'hFF, 1'b0, 1'b0, 8'h07, 14'h3F06, 16'h001A);
    t_read(8'h05, 8'h12, 1'b1, 1'b1, 8'h03, 14'h3F05, 16'hA50F);
    t_read(8'h80, 8'h01, 1'b0, 1'b1, 8'hFE, 14'h0180, 16'hC3E1);
    t_read(8'hFF, 8'hC0, 1'b0, 1'b0, 8'h00, 14'h00FF, 16'h8001);
    wr8(2, 8'h9C);
    chk({8'h00, table_high_latch}, 16'h009C);
    debug_variant = 1'b1;
    prog_go = 1'b1;
    repeat (50) @(negedge clk);
    chk({8'h00, rx_sr}, 16'h000B);
    {prog_tx_en, prog_tx_bit} = 2'b11;
    repeat (2) @(negedge clk);
    chk({14'h0000, prog_serial_data_oe, prog_serial_data_out}, 16'h0003);
    chk({15'h0000, shared_func_en}, 16'h0000);
    summarize();
  end
endmodule : test_pmtr_reader
